// ==== src/brake_ctl_pkg.sv ====
// Purpose: Shared constants and types for the power-loss brake and config block
// Assumes: 25 MHz mclk, comparator levels arrive asynchronously from analog
// Notes: Register offsets are the byte-free I2C register addresses
// Behaviour
// - Sense low below brake threshold, or sense high below lockout: coast.
// - Brake by turning on all three low-side transistors together.
// - Sense low, supply between threshold and boost level: PWM brake.
// - Brake is released briefly so winding current charges supply capacitor.
// - At boost level the supply is regulated by hysteretic brake release.
// - Above boost level: continuous brake, no release pulses.
// - Sense high above lockout: run, motor starts only with valid command.
// - Unpowered, spun externally: brake once supply exceeds brake threshold.
// - Nonvolatile word copied into shadow before control uses it.
// - Host reads and writes shadow directly; writes after the load act immediately, earlier ones are ignored.
// - Nonvolatile writes never change running behaviour until power cycle.
// - Bits 2:0 allow value plus one errors before windmill error.
// - Bits 5:3 allow value plus one timeouts before rotor is stationary.
// - Bits 8:6 give value plus one windmill assessments.
// - Bit 9 prescaler: tick is one clock when zero, two when one.
// - Bits 12:10 pick timeout 20..562 ms, doubled with prescaler set.
// - Bits 18:14 blanking is (N+1) times 135 times prescale clocks.
// - Bits 26:22 debounce is two to the power N ticks.
// - Bits 31:27 slew step is base fraction times two to the N.
package brake_ctl_pkg;

    localparam int CLK_PERIOD_NS = 40;
    localparam int CLK_PER_MS = 1000000 / CLK_PERIOD_NS;

    // I2C register addresses
    localparam logic [11:0] ADDR_WCFG_SHADOW = 12'h460;
    localparam logic [11:0] ADDR_WCFG_NVM = 12'h4c0;
    localparam logic [7:0] NVM_WCFG_WORD = 8'h00;
    localparam logic [31:0] SHADOW_RESET = 32'h0000_0000;

    // Field positions of the windmill configuration word
    localparam int F_ERR_LO = 0;
    localparam int F_TO_LO = 3;
    localparam int F_ASSESS_LO = 6;
    localparam int F_PRESCALE = 9;
    localparam int F_TSEL_LO = 10;
    localparam int F_BLANK_LO = 14;
    localparam int F_DEB_LO = 22;
    localparam int F_SLEW_LO = 27;
    localparam int BLANK_UNIT_CYC = 135;

    // Timeout table in milliseconds
    localparam int TO_MS_0 = 20;
    localparam int TO_MS_1 = 40;
    localparam int TO_MS_2 = 81;
    localparam int TO_MS_3 = 121;
    localparam int TO_MS_4 = 162;
    localparam int TO_MS_5 = 202;
    localparam int TO_MS_6 = 243;
    localparam int TO_MS_7 = 562;

    // Brake PWM timing
    localparam int BRAKE_PERIOD_NS = 40000;
    localparam int BRAKE_RELEASE_NS = 4000;
    localparam int BRAKE_PERIOD_CYC = BRAKE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int BRAKE_RELEASE_CYC = (BRAKE_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Comparator bit positions in the level vectors
    localparam int C_SENSE = 0;
    localparam int C_TH = 1;
    localparam int C_BOOST = 2;
    localparam int C_OVER = 3;
    localparam int C_UVLO = 4;

    typedef enum logic [2:0] {
        MODE_COAST = 3'b000,
        MODE_PWM_BRAKE = 3'b001,
        MODE_BOOST_BRAKE = 3'b010,
        MODE_FULL_BRAKE = 3'b011,
        MODE_RUN = 3'b100
    } brake_mode_t;

    typedef enum logic [1:0] {
        LD_REQ = 2'b00,
        LD_WAIT = 2'b01,
        LD_DONE = 2'b10
    } load_state_t;

    typedef struct packed {
        logic [3:0] err_limit;
        logic [3:0] timeout_limit;
        logic [3:0] assess_count;
        logic [1:0] tick_div;
        logic [24:0] timeout_cyc;
        logic [13:0] blank_cyc;
        logic [31:0] debounce_ticks;
        logic [4:0] slew_shift;
    } spin_cfg_t;

    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [4:0] sync3;
        logic [4:0] lvl;
        load_state_t load;
        logic nvm_rd_en;
        logic nvm_wr_en;
        logic [31:0] nvm_wdata;
        logic [31:0] shadow;
        logic [31:0] nvm_image;
        logic [31:0] rdata;
        brake_mode_t mode;
        logic boost_reached;
        logic [9:0] pwm_cnt;
        logic [2:0] low_side_on;
        logic motor_run;
        spin_cfg_t cfg;
    } ctl_state_t;

endpackage

// ==== src/power_loss_brake_control.sv ====
// Purpose: Power-loss brake mode selection and windmill config shadow
// Assumes: Comparator levels asynchronous; register port driven by I2C engine
// Notes: Single nonvolatile word loaded once after reset release
`timescale 1ns/10ps
module power_loss_brake_control (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sense_above_threshold,
    input wire logic supply_above_brake_threshold,
    input wire logic supply_at_boost_level,
    input wire logic supply_over_boost_level,
    input wire logic supply_above_lockout,
    input wire logic speed_cmd_valid,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic nvm_rd_en,
    output logic [7:0] nvm_addr,
    input wire logic nvm_rd_valid,
    input wire logic [31:0] nvm_rdata,
    output logic nvm_wr_en,
    output logic [31:0] nvm_wdata,
    output logic config_ready,
    output logic [2:0] low_side_on,
    output logic motor_run,
    output logic [2:0] brake_mode,
    output brake_ctl_pkg::spin_cfg_t spin_cfg
);

    brake_ctl_pkg::ctl_state_t st_r;
    brake_ctl_pkg::ctl_state_t st_nxt;

    // Timeout in cycles from selector; prescaler doubles it
    function automatic logic [24:0] timeout_cycles(input logic [2:0] sel, input logic pre);
        int ms;
        logic [24:0] cyc;
        ms = 0;
        unique case (sel)
            3'h0: ms = brake_ctl_pkg::TO_MS_0;
            3'h1: ms = brake_ctl_pkg::TO_MS_1;
            3'h2: ms = brake_ctl_pkg::TO_MS_2;
            3'h3: ms = brake_ctl_pkg::TO_MS_3;
            3'h4: ms = brake_ctl_pkg::TO_MS_4;
            3'h5: ms = brake_ctl_pkg::TO_MS_5;
            3'h6: ms = brake_ctl_pkg::TO_MS_6;
            3'h7: ms = brake_ctl_pkg::TO_MS_7;
        endcase
        cyc = 25'(ms * brake_ctl_pkg::CLK_PER_MS);
        timeout_cycles = pre ? 25'(cyc << 1) : cyc;
    endfunction

    // Decode the configuration word into ready-to-use counts
    function automatic brake_ctl_pkg::spin_cfg_t decode_cfg(input logic [31:0] w);
        brake_ctl_pkg::spin_cfg_t c;
        logic pre;
        pre = w[brake_ctl_pkg::F_PRESCALE];
        c.err_limit = {1'b0, w[brake_ctl_pkg::F_ERR_LO +: 3]} + 4'h1;
        c.timeout_limit = {1'b0, w[brake_ctl_pkg::F_TO_LO +: 3]} + 4'h1;
        c.assess_count = {1'b0, w[brake_ctl_pkg::F_ASSESS_LO +: 3]} + 4'h1;
        c.tick_div = pre ? 2'h2 : 2'h1;
        c.timeout_cyc = timeout_cycles(w[brake_ctl_pkg::F_TSEL_LO +: 3], pre);
        c.blank_cyc = 14'(({9'h000, w[brake_ctl_pkg::F_BLANK_LO +: 5]} + 14'h0001)
                      * 14'(brake_ctl_pkg::BLANK_UNIT_CYC) * {12'h000, c.tick_div});
        c.debounce_ticks = 32'h0000_0001 << w[brake_ctl_pkg::F_DEB_LO +: 5];
        c.slew_shift = w[brake_ctl_pkg::F_SLEW_LO +: 5];
        decode_cfg = c;
    endfunction

    // Next-state logic for the whole block
    always_comb begin
        logic [4:0] raw;
        logic brake_on;
        raw = 5'h00;
        brake_on = 1'b0;
        st_nxt = st_r;
        st_nxt.nvm_rd_en = 1'b0;
        st_nxt.nvm_wr_en = 1'b0;

        // Three-stage synchroniser; a level moves only when stages two and three agree
        raw[brake_ctl_pkg::C_SENSE] = sense_above_threshold;
        raw[brake_ctl_pkg::C_TH] = supply_above_brake_threshold;
        raw[brake_ctl_pkg::C_BOOST] = supply_at_boost_level;
        raw[brake_ctl_pkg::C_OVER] = supply_over_boost_level;
        raw[brake_ctl_pkg::C_UVLO] = supply_above_lockout;
        st_nxt.sync1 = raw;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;
        for (int i = 0; i < 5; i++) begin
            if (st_r.sync2[i] == st_r.sync3[i]) begin
                st_nxt.lvl[i] = st_r.sync3[i];
            end
        end

        // One-time copy of the nonvolatile word into the shadow
        unique case (st_r.load)
            brake_ctl_pkg::LD_REQ: begin
                st_nxt.nvm_rd_en = 1'b1;
                st_nxt.load = brake_ctl_pkg::LD_WAIT;
            end
            brake_ctl_pkg::LD_WAIT: begin
                if (nvm_rd_valid) begin
                    st_nxt.shadow = nvm_rdata;
                    st_nxt.nvm_image = nvm_rdata;
                    st_nxt.cfg = decode_cfg(nvm_rdata);
                    st_nxt.load = brake_ctl_pkg::LD_DONE;
                end
            end
            brake_ctl_pkg::LD_DONE: begin
                st_nxt.load = brake_ctl_pkg::LD_DONE;
            end
            default: begin
                st_nxt.load = brake_ctl_pkg::LD_REQ;
            end
        endcase

        // Host writes; ignored until the shadow is loaded so the copy is not overwritten
        if (reg_wr && st_r.load == brake_ctl_pkg::LD_DONE) begin
            if (reg_addr == brake_ctl_pkg::ADDR_WCFG_SHADOW) begin
                st_nxt.shadow = reg_wdata;
                st_nxt.cfg = decode_cfg(reg_wdata);
            end else if (reg_addr == brake_ctl_pkg::ADDR_WCFG_NVM) begin
                // Shadow and decoded values untouched until next power cycle
                st_nxt.nvm_wr_en = 1'b1;
                st_nxt.nvm_wdata = reg_wdata;
                st_nxt.nvm_image = reg_wdata;
            end
        end

        // Read data, zero for unmapped addresses
        if (reg_rd) begin
            if (reg_addr == brake_ctl_pkg::ADDR_WCFG_SHADOW) begin
                st_nxt.rdata = st_r.shadow;
            end else if (reg_addr == brake_ctl_pkg::ADDR_WCFG_NVM) begin
                st_nxt.rdata = st_r.nvm_image;
            end else begin
                st_nxt.rdata = 32'h0000_0000;
            end
        end

        // Mode from synchronised levels only
        if (!st_r.lvl[brake_ctl_pkg::C_SENSE]) begin
            if (!st_r.lvl[brake_ctl_pkg::C_TH]) begin
                st_nxt.mode = brake_ctl_pkg::MODE_COAST;
            end else if (st_r.lvl[brake_ctl_pkg::C_OVER]) begin
                st_nxt.mode = brake_ctl_pkg::MODE_FULL_BRAKE;
            end else if (st_r.boost_reached || st_r.lvl[brake_ctl_pkg::C_BOOST]) begin
                st_nxt.mode = brake_ctl_pkg::MODE_BOOST_BRAKE;
            end else begin
                st_nxt.mode = brake_ctl_pkg::MODE_PWM_BRAKE;
            end
        end else if (st_r.lvl[brake_ctl_pkg::C_UVLO]) begin
            st_nxt.mode = brake_ctl_pkg::MODE_RUN;
        end else begin
            st_nxt.mode = brake_ctl_pkg::MODE_COAST;
        end

        // Boost regulation holds once the level is met, until braking stops
        if (st_r.lvl[brake_ctl_pkg::C_SENSE] || !st_r.lvl[brake_ctl_pkg::C_TH]) begin
            st_nxt.boost_reached = 1'b0;
        end else if (st_r.lvl[brake_ctl_pkg::C_BOOST]) begin
            st_nxt.boost_reached = 1'b1;
        end

        // Brake PWM period counter, restarted outside PWM braking
        if (st_r.mode != brake_ctl_pkg::MODE_PWM_BRAKE
            || st_r.pwm_cnt == 10'(brake_ctl_pkg::BRAKE_PERIOD_CYC - 1)) begin
            st_nxt.pwm_cnt = 10'h000;
        end else begin
            st_nxt.pwm_cnt = st_r.pwm_cnt + 10'h001;
        end

        // Low-side drive per mode; releases let winding current lift the supply
        unique case (st_r.mode)
            brake_ctl_pkg::MODE_PWM_BRAKE: begin
                brake_on = st_r.pwm_cnt >= 10'(brake_ctl_pkg::BRAKE_RELEASE_CYC);
            end
            brake_ctl_pkg::MODE_BOOST_BRAKE: begin
                brake_on = st_r.lvl[brake_ctl_pkg::C_BOOST];
            end
            brake_ctl_pkg::MODE_FULL_BRAKE: begin
                brake_on = 1'b1;
            end
            brake_ctl_pkg::MODE_COAST, brake_ctl_pkg::MODE_RUN: begin
                brake_on = 1'b0;
            end
            default: begin
                brake_on = 1'b0;
            end
        endcase
        st_nxt.low_side_on = {3{brake_on}};

        // Run needs loaded config and a valid speed command
        st_nxt.motor_run = st_r.mode == brake_ctl_pkg::MODE_RUN && speed_cmd_valid
                           && st_r.load == brake_ctl_pkg::LD_DONE;
    end

    // State register, synchronous reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.load <= brake_ctl_pkg::LD_REQ;
            st_r.mode <= brake_ctl_pkg::MODE_COAST;
            st_r.shadow <= brake_ctl_pkg::SHADOW_RESET;
            st_r.cfg <= decode_cfg(brake_ctl_pkg::SHADOW_RESET);
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register, except nvm_addr which is a constant and config_ready decoded from the load state
    assign reg_rdata = st_r.rdata;
    assign nvm_rd_en = st_r.nvm_rd_en;
    assign nvm_addr = brake_ctl_pkg::NVM_WCFG_WORD;
    assign nvm_wr_en = st_r.nvm_wr_en;
    assign nvm_wdata = st_r.nvm_wdata;
    assign config_ready = st_r.load == brake_ctl_pkg::LD_DONE;
    assign low_side_on = st_r.low_side_on;
    assign motor_run = st_r.motor_run;
    assign brake_mode = st_r.mode;
    assign spin_cfg = st_r.cfg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Helper: cycles spent in PWM braking with brake held on
    logic [10:0] on_run_r;
    always_ff @(posedge mclk) begin
        if (!rst_n || !(low_side_on[0] && brake_mode == brake_ctl_pkg::MODE_PWM_BRAKE)) begin
            on_run_r <= 11'h000;
        end else begin
            on_run_r <= on_run_r + 11'h001;
        end
    end

    AST_COAST_NO_BRAKE: assert property (
        brake_mode == brake_ctl_pkg::MODE_COAST |=> low_side_on == 3'b000
    ) else $error("Low side on while coasting");

    AST_ALL_LOW_TOGETHER: assert property (
        low_side_on == 3'b000 || low_side_on == 3'b111
    ) else $error("Low sides not switched together");

    AST_PWM_RELEASES: assert property (
        on_run_r <= 11'(brake_ctl_pkg::BRAKE_PERIOD_CYC)
    ) else $error("PWM brake never released");

    AST_FULL_BRAKE_HOLD: assert property (
        brake_mode == brake_ctl_pkg::MODE_FULL_BRAKE |=> low_side_on == 3'b111
    ) else $error("Full brake not continuous");

    AST_RUN_NEEDS_CMD: assert property (
        motor_run |-> $past(speed_cmd_valid) && $past(brake_mode == brake_ctl_pkg::MODE_RUN)
    ) else $error("Run without valid command");

    AST_LOAD_BEFORE_USE: assert property (
        $rose(config_ready) |-> $past(nvm_rd_valid) && spin_cfg == decode_cfg($past(nvm_rdata))
    ) else $error("Config not taken from loaded shadow");

    AST_SHADOW_WRITE_NOW: assert property (
        reg_wr && config_ready && reg_addr == brake_ctl_pkg::ADDR_WCFG_SHADOW
        |=> spin_cfg == decode_cfg($past(reg_wdata))
    ) else $error("Shadow write not applied at once");

    AST_NVM_WRITE_INERT: assert property (
        reg_wr && config_ready && reg_addr == brake_ctl_pkg::ADDR_WCFG_NVM |=> $stable(spin_cfg) ##0 nvm_wr_en
    ) else $error("Nonvolatile write changed behaviour");

    AST_TICK_DIV: assert property (
        spin_cfg.tick_div == 2'h1 || spin_cfg.tick_div == 2'h2
    ) else $error("Prescaler tick out of range");

    AST_SYNC_DELAY: assert property (
        $rose(sense_above_threshold) ##1 sense_above_threshold [*4]
        |-> ##[0:1] st_r.lvl[brake_ctl_pkg::C_SENSE]
    ) else $error("Sense level not synchronised in time");

    // Mode table, one cycle after the synchronised levels settle
    AST_MODE_COAST_LOW: assert property (
        !st_r.lvl[brake_ctl_pkg::C_SENSE] && !st_r.lvl[brake_ctl_pkg::C_TH]
        |=> brake_mode == brake_ctl_pkg::MODE_COAST
    ) else $error("No coast with low sense below threshold");

    AST_MODE_COAST_UVLO: assert property (
        st_r.lvl[brake_ctl_pkg::C_SENSE] && !st_r.lvl[brake_ctl_pkg::C_UVLO]
        |=> brake_mode == brake_ctl_pkg::MODE_COAST
    ) else $error("No coast below lockout");

    AST_MODE_PWM: assert property (
        !st_r.lvl[brake_ctl_pkg::C_SENSE] && st_r.lvl[brake_ctl_pkg::C_TH] && !st_r.lvl[brake_ctl_pkg::C_OVER]
        && !st_r.lvl[brake_ctl_pkg::C_BOOST] && !st_r.boost_reached
        |=> brake_mode == brake_ctl_pkg::MODE_PWM_BRAKE
    ) else $error("PWM brake not selected");

    AST_MODE_FULL: assert property (
        !st_r.lvl[brake_ctl_pkg::C_SENSE] && st_r.lvl[brake_ctl_pkg::C_TH] && st_r.lvl[brake_ctl_pkg::C_OVER]
        |=> brake_mode == brake_ctl_pkg::MODE_FULL_BRAKE
    ) else $error("Full brake not selected above boost level");

    AST_MODE_RUN: assert property (
        st_r.lvl[brake_ctl_pkg::C_SENSE] && st_r.lvl[brake_ctl_pkg::C_UVLO]
        |=> brake_mode == brake_ctl_pkg::MODE_RUN
    ) else $error("Run mode not selected");

    // Gate pattern in the two pulsing modes
    AST_PWM_RELEASE_START: assert property (
        brake_mode == brake_ctl_pkg::MODE_PWM_BRAKE && st_r.pwm_cnt == 10'h000
        |=> low_side_on == 3'b000
    ) else $error("PWM period does not open with a release");

    AST_BOOST_FOLLOWS_LEVEL: assert property (
        brake_mode == brake_ctl_pkg::MODE_BOOST_BRAKE
        |=> low_side_on == {3{$past(st_r.lvl[brake_ctl_pkg::C_BOOST])}}
    ) else $error("Boost brake not following the boost level");

    // Load sequencing and register side effects
    AST_LOAD_ONCE: assert property (
        config_ready |-> !nvm_rd_en
    ) else $error("Store read requested after load");

    AST_READY_STICKY: assert property (
        config_ready |=> config_ready
    ) else $error("Config ready dropped without reset");

    AST_NO_RUN_UNLOADED: assert property (
        !config_ready |-> !motor_run
    ) else $error("Motor run before config load");

    AST_EARLY_WRITE_IGNORED: assert property (
        reg_wr && !config_ready && !nvm_rd_valid
        |=> $stable(st_r.shadow)
    ) else $error("Shadow written before load");

    AST_SHADOW_READBACK: assert property (
        reg_rd && reg_addr == brake_ctl_pkg::ADDR_WCFG_SHADOW
        |=> reg_rdata == $past(st_r.shadow)
    ) else $error("Shadow read data wrong");

    AST_NVM_WDATA: assert property (
        reg_wr && config_ready && reg_addr == brake_ctl_pkg::ADDR_WCFG_NVM
        |=> nvm_wdata == $past(reg_wdata)
    ) else $error("Store write data wrong");

endmodule

// ==== test/nvm_store_model.sv ====
// Purpose: Nonvolatile store model that answers the shadow load request
// Assumes: One configuration word; read latency set by the bench per run
// Notes: Data bus inverts every bit on each cycle whenever it is not valid
`timescale 1ns/10ps
module nvm_store_model #(
    parameter logic [31:0] INIT_WORD = 32'h0000_0000
) (
    input wire logic mclk,
    input wire logic [7:0] nvm_addr,
    input wire logic nvm_rd_en,
    input wire logic nvm_wr_en,
    input wire logic [31:0] nvm_wdata,
    input wire logic [7:0] latency,
    output logic nvm_rd_valid,
    output logic [31:0] nvm_rdata
);
    logic [31:0] image_r = INIT_WORD;
    int wait_cnt = -1;

    initial begin
        nvm_rd_valid = 1'b0;
        nvm_rdata = 32'ha5a5_5a5a;
    end

    // Stored writes are seen only by the next load, never at once
    always @(posedge mclk) begin
        nvm_rd_valid <= 1'b0;
        nvm_rdata <= ~nvm_rdata;
        if (nvm_wr_en) begin
            image_r <= nvm_wdata;
        end
        if (nvm_rd_en && nvm_addr == 8'h00) begin
            wait_cnt <= int'(latency);
        end else if (wait_cnt == 0) begin
            nvm_rd_valid <= 1'b1;
            nvm_rdata <= image_r;
            wait_cnt <= -1;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end
    end
endmodule

// ==== test/power_loss_brake_control_test.sv ====
// Purpose: Self-checking bench for brake mode selection and config shadow
// Assumes: Comparator levels driven directly; store model answers loads
// Notes: Mode and field decode come from small behavioural models here
`timescale 1ns/10ps
module power_loss_brake_control_test;
    localparam logic [31:0] INIT_WORD = 32'h9c3e_15a7;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] cmp = 5'h00;
    logic spd = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic nvm_rd_en;
    logic [7:0] nvm_addr;
    logic nvm_rd_valid;
    logic [31:0] nvm_rdata;
    logic nvm_wr_en;
    logic [31:0] nvm_wdata;
    logic config_ready;
    logic [2:0] low_side_on;
    logic motor_run;
    logic [2:0] brake_mode;
    brake_ctl_pkg::spin_cfg_t spin_cfg;
    logic [7:0] latency = 8'h03;
    logic [15:0] lfsr = 16'h6f97;
    logic [31:0] w;
    logic [31:0] d;
    logic [31:0] nv;
    int n_mismatch = 0;
    int num_checks = 0;
    int latch_b = 0;
    int n;

    always #20 mclk = ~mclk;

    power_loss_brake_control i_dut (.mclk(mclk), .rst_n(rst_n), .sense_above_threshold(cmp[0]),
        .supply_above_brake_threshold(cmp[1]), .supply_at_boost_level(cmp[2]),
        .supply_over_boost_level(cmp[3]), .supply_above_lockout(cmp[4]), .speed_cmd_valid(spd),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .nvm_rd_en(nvm_rd_en), .nvm_addr(nvm_addr), .nvm_rd_valid(nvm_rd_valid),
        .nvm_rdata(nvm_rdata), .nvm_wr_en(nvm_wr_en), .nvm_wdata(nvm_wdata), .config_ready(config_ready),
        .low_side_on(low_side_on), .motor_run(motor_run), .brake_mode(brake_mode), .spin_cfg(spin_cfg));

    nvm_store_model #(.INIT_WORD(INIT_WORD)) i_nvm (.mclk(mclk), .nvm_addr(nvm_addr), .nvm_rd_en(nvm_rd_en),
        .nvm_wr_en(nvm_wr_en), .nvm_wdata(nvm_wdata), .latency(latency), .nvm_rd_valid(nvm_rd_valid),
        .nvm_rdata(nvm_rdata));

    // Inputs change 1 ns after the rising edge, never on it
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] rnd32();
        for (int i = 0; i < 32; i++) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
        return {lfsr, lfsr ^ 16'h3c5a};
    endfunction

    // Field decode written from the configuration word layout
    function automatic brake_ctl_pkg::spin_cfg_t exp_cfg(input logic [31:0] v);
        brake_ctl_pkg::spin_cfg_t c;
        int ms[8] = '{20, 40, 81, 121, 162, 202, 243, 562};
        int dv;
        dv = v[9] ? 2 : 1;
        c.err_limit = 4'(v[2:0]) + 4'h1;
        c.timeout_limit = 4'(v[5:3]) + 4'h1;
        c.assess_count = 4'(v[8:6]) + 4'h1;
        c.tick_div = 2'(dv);
        c.timeout_cyc = 25'(ms[v[12:10]] * 25000 * dv);
        c.blank_cyc = 14'((int'(v[18:14]) + 1) * 135 * dv);
        c.debounce_ticks = 32'h1 << v[26:22];
        c.slew_shift = v[31:27];
        return c;
    endfunction

    // Mode table; bits are sense, threshold, boost, over-boost, lockout
    function automatic logic [2:0] model_mode(input logic [4:0] c);
        if (c[0] || !c[1]) begin
            latch_b = 0;
            return (c[0] && c[4]) ? 3'h4 : 3'h0;
        end
        if (c[3]) begin
            return 3'h3;
        end
        if (c[2]) begin
            latch_b = 1;
        end
        return (latch_b != 0) ? 3'h2 : 3'h1;
    endfunction

    task automatic reg_write(input logic [11:0] a, input logic [31:0] v);
        tick(1);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
    endtask

    task automatic reg_read(input logic [11:0] a, output logic [31:0] v);
        tick(1);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        tick(1);
        v = reg_rdata;
    endtask

    // Reset, then wait for the load; a slow load also sees an early write
    task automatic do_reset(input logic [31:0] img, input logic [7:0] lat);
        int k;
        logic [31:0] v;
        latency = lat;
        latch_b = 0;
        rst_n = 1'b0;
        tick(2);
        chk(spin_cfg, exp_cfg(32'h0), "reset decode");
        chk({config_ready, low_side_on, motor_run, brake_mode, nvm_wr_en}, 0, "reset outputs");
        rst_n = 1'b1;
        k = 0;
        while (nvm_rd_en !== 1'b1 && k < 4) begin
            tick(1);
            k++;
        end
        chk({k < 4, nvm_addr}, 9'h100, "load request");
        if (lat > 8'h10) begin
            reg_write(12'h460, ~img);
        end
        k = 0;
        while (config_ready !== 1'b1 && k < 200) begin
            tick(1);
            k++;
        end
        if (k >= 200) begin
            n_mismatch++;
            wrap_up();
        end
        reg_read(12'h460, v);
        chk(v, img, "shadow load");
        chk(spin_cfg, exp_cfg(img), "loaded decode");
    endtask

    // Settle the levels, then count low-side on cycles over one brake period
    task automatic set_cmp(input logic [4:0] c);
        int on;
        logic [2:0] m;
        m = model_mode(c);
        cmp = c;
        tick(8);
        chk(brake_mode, m, "mode");
        chk(motor_run, m == 3'h4 && spd, "run enable");
        on = 0;
        repeat (1000) begin
            if (low_side_on === 3'b111) begin
                on++;
            end else if (low_side_on !== 3'b000) begin
                chk(low_side_on, 3'b000, "gates unequal");
            end
            tick(1);
        end
        chk(on, m == 3'h1 ? 900 : (m == 3'h3 || (m == 3'h2 && c[2])) ? 1000 : 0, "on cycles");
    endtask

    initial begin
        do_reset(INIT_WORD, 8'h03);
        for (int i = 0; i < 9; i++) begin
            w = (i == 8) ? 32'hffff_ffff : rnd32();
            if (i < 8) begin
                w[12:10] = 3'(i);
                w[9] = i[0] ^ i[1];
            end
            reg_write(12'h460, w);
            tick(2);
            chk(spin_cfg, exp_cfg(w), "decode");
            reg_read(12'h460, d);
            chk(d, w, "shadow readback");
        end
        nv = rnd32();
        reg_write(12'h4c0, nv);
        n = 0;
        repeat (3) begin
            n += int'(nvm_wr_en === 1'b1);
            tick(1);
        end
        chk(n, 1, "store write pulse");
        chk(nvm_wdata, nv, "store write data");
        chk(spin_cfg, exp_cfg(w), "store write inert");
        reg_read(12'h4c0, d);
        chk(d, nv, "store readback");
        reg_write(12'h461, rnd32());
        reg_read(12'h461, d);
        chk(d, 0, "unmapped read");
        reg_read(12'h460, d);
        chk(d, w, "shadow kept");
        // Standby with no speed command, then restart under the new settings
        set_cmp(5'h11);
        spd = 1'b1;
        set_cmp(5'h11);
        set_cmp(5'h01);
        set_cmp(5'h00);
        set_cmp(5'h02);
        set_cmp(5'h06);
        set_cmp(5'h02);
        set_cmp(5'h0e);
        set_cmp(5'h00);
        set_cmp(5'h02);
        do_reset(nv, 8'h28);
        set_cmp(5'h02);
        wrap_up();
    end
endmodule
